// ===== rtl/qlc_fabric.sv
// Top of the quadrant logic fabric: pin sync, input latches, buses, cells, scan chain.
// Assumes the configuration inputs are static and free of combinational loops.
`timescale 1ns/1ns
// Operation
// - 52 I/O cells, 24 buried, four quadrants
// - I/O cell: two flops, three sums, terms
// - Both I/O flops usable, flop 1 four to twelve terms, flop 2 four
// - Pin direct or latched, latch clock per quadrant
// - Universal bus: true and complement of pins
// - Regional bus: quadrant flops plus eight inputs
// - Buried cell: one flop, sum feeds back
// - All registers clear at power-up
// - Serial preload and readback of registers
// - Sum terms wire-OR, buried sums re-enter
// - Pin from register or sum, latch enable
// - Product-term clock or input-pin clock
module qlc_fabric
  import qlc_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [QLC_IO-1:0] io_pin_in,
  output logic [QLC_IO-1:0] io_pin_out,
  output logic [QLC_IO-1:0] io_pin_oe_out,
  input wire logic [QLC_DED-1:0] ded_pin_in,
  input wire logic scan_en_in,
  input wire logic scan_data_in,
  output logic scan_data_out,
  input wire qlc_io_cfg_type [QLC_IO-1:0] io_cfg_in,
  input wire qlc_bur_cfg_type [QLC_BUR-1:0] bur_cfg_in,
  input wire qlc_pt_type [QLC_QUADS-1:0] lat_pt_in
);
  // AND of the selected literals; an empty term reads as true
  function automatic logic pt_eval(input qlc_pt_type mask, input qlc_pt_type lits);
    pt_eval = &(lits | ~mask);
  endfunction

  // Wired-OR of one group of four product terms
  function automatic logic sum_eval(input qlc_sum_type masks, input qlc_pt_type lits);
    logic acc;
    acc = 1'b0;
    for (int k = 0; k < QLC_SUM_PTS; k++) begin
      acc = acc | pt_eval(masks[k*QLC_LITS +: QLC_LITS], lits);
    end
    sum_eval = acc;
  endfunction

  logic [QLC_IO-1:0] io_meta_q, io_sync_q;
  logic [QLC_DED-1:0] ded_meta_q, ded_sync_q;
  logic [1:0] scan_meta_q, scan_sync_q;
  logic [QLC_IO-1:0] lat_q;
  logic [QLC_IO-1:0] lat_gate;
  logic [QLC_IO-1:0] pin_val;
  logic [QLC_QUADS-1:0] lat_clk;
  logic [QLC_IO-1:0] ff1_q, ff2_q;
  logic [QLC_BUR-1:0] bur_q;
  logic [QLC_QUADS-1:0][QLC_BUR_PER_Q-1:0] fb_sum;
  logic [QLC_FF-1:0] all_q, chain_in;
  logic [2*QLC_IO-1:0] uni_bus;
  logic [QLC_IO-1:0] comb_mask;
  logic [QLC_SCAN_CNT_W-1:0] scan_cnt_q;

  // Two-flop synchronisers for every pin; first stage feeds only the second
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      io_meta_q <= '0;
      io_sync_q <= '0;
      ded_meta_q <= '0;
      ded_sync_q <= '0;
      scan_meta_q <= 2'h0;
      scan_sync_q <= 2'h0;
    end else begin
      io_meta_q <= io_pin_in;
      io_sync_q <= io_meta_q;
      ded_meta_q <= ded_pin_in;
      ded_sync_q <= ded_meta_q;
      scan_meta_q <= {scan_en_in, scan_data_in};
      scan_sync_q <= scan_meta_q;
    end
  end

  // Latch follows its pin while the quadrant clock and its own enable are high
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lat_q <= '0;
    end else begin
      lat_q <= (lat_q & ~lat_gate) | (io_sync_q & lat_gate);
    end
  end

  // Universal bus: every pin, true and complement, into all quadrants
  assign uni_bus = {~pin_val, pin_val};

  // Scan chain runs io flop 1s, then io flop 2s, then buried flops
  assign all_q = {bur_q, ff2_q, ff1_q};
  assign chain_in = {all_q[QLC_FF-2:0], scan_sync_q[0]};
  assign scan_data_out = all_q[QLC_FF-1];

  // Helper: consecutive cycles of shifting, saturating
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scan_cnt_q <= '0;
    end else if (!scan_sync_q[1]) begin
      scan_cnt_q <= '0;
    end else if (scan_cnt_q != '1) begin
      scan_cnt_q <= scan_cnt_q + 1'b1;
    end
  end

  for (genvar gq = 0; gq < QLC_QUADS; gq++) begin : g_quad
    logic [QLC_REG_FF-1:0] reg_q;
    qlc_pt_type lits;

    // Regional bus: this quadrant's flops and all dedicated inputs
    assign reg_q = {bur_q[gq*QLC_BUR_PER_Q +: QLC_BUR_PER_Q],
                    ff2_q[gq*QLC_IO_PER_Q +: QLC_IO_PER_Q],
                    ff1_q[gq*QLC_IO_PER_Q +: QLC_IO_PER_Q]};
    assign lits = {fb_sum[gq], ~ded_sync_q, ded_sync_q, ~reg_q, reg_q, uni_bus};
    // One shared latch clock per quadrant
    assign lat_clk[gq] = pt_eval(lat_pt_in[gq], lits);

    for (genvar gc = 0; gc < QLC_IO_PER_Q; gc++) begin : g_io
      localparam int I = gq * QLC_IO_PER_Q + gc;
      logic s0, s1, s2, comb;
      qlc_ff_ctl_type ctl1, ctl2;

      assign lat_gate[I] = lat_clk[gq] & io_cfg_in[I].lat_en;
      assign pin_val[I] = io_cfg_in[I].lat_use ? lat_q[I] : io_sync_q[I];
      assign comb_mask[I] = io_cfg_in[I].comb_out;

      // Three sum terms of four product terms each
      assign s0 = sum_eval(io_cfg_in[I].pt[QLC_PT_S0 +: QLC_SUM_PTS], lits);
      assign s1 = sum_eval(io_cfg_in[I].pt[QLC_PT_S1 +: QLC_SUM_PTS], lits);
      assign s2 = sum_eval(io_cfg_in[I].pt[QLC_PT_S2 +: QLC_SUM_PTS], lits);

      // Output sum widens to 8 or 12 terms by wired-OR
      assign comb = s0 | (io_cfg_in[I].comb_w != QLC_W4 & s1) |
                    (io_cfg_in[I].comb_w != QLC_W4 & io_cfg_in[I].comb_w != QLC_W8 & s2);

      // Middle group always reaches flop 1, bottom group flop 2, whatever the output uses
      assign ctl1.d = s1 | (~io_cfg_in[I].comb_out & s0) | (io_cfg_in[I].share2 & s2);
      assign ctl1.clk_pt = pt_eval(io_cfg_in[I].pt[QLC_PT_CLK1], lits);
      assign ctl1.rst = pt_eval(io_cfg_in[I].pt[QLC_PT_RST1], lits);
      assign ctl1.pre = pt_eval(io_cfg_in[I].pt[QLC_PT_PRE1], lits);
      assign ctl2.d = s2;
      assign ctl2.clk_pt = pt_eval(io_cfg_in[I].pt[QLC_PT_CLK2], lits);
      assign ctl2.rst = pt_eval(io_cfg_in[I].pt[QLC_PT_RST2], lits);
      assign ctl2.pre = pt_eval(io_cfg_in[I].pt[QLC_PT_PRE2], lits);

      // Pin from flop 1 or straight from the sum; enable from its own term
      assign io_pin_out[I] = io_cfg_in[I].comb_out ? comb : ff1_q[I];
      assign io_pin_oe_out[I] = pt_eval(io_cfg_in[I].pt[QLC_PT_OE], lits);

      qlc_ff u_ff1 (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .ctl_in(ctl1),
        .clk_src_in(io_cfg_in[I].clk[0]),
        .ded_sync_in(ded_sync_q),
        .scan_en_in(scan_sync_q[1]),
        .scan_d_in(chain_in[I]),
        .q_out(ff1_q[I])
      );

      qlc_ff u_ff2 (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .ctl_in(ctl2),
        .clk_src_in(io_cfg_in[I].clk[1]),
        .ded_sync_in(ded_sync_q),
        .scan_en_in(scan_sync_q[1]),
        .scan_d_in(chain_in[QLC_IO + I]),
        .q_out(ff2_q[I])
      );
    end

    for (genvar gb = 0; gb < QLC_BUR_PER_Q; gb++) begin : g_bur
      localparam int B = gq * QLC_BUR_PER_Q + gb;
      qlc_ff_ctl_type ctl;

      // Buried sum feeds its flop and re-enters the regional bus
      assign fb_sum[gq][gb] = sum_eval(bur_cfg_in[B].pt[QLC_BPT_S0 +: QLC_SUM_PTS], lits);
      assign ctl.d = fb_sum[gq][gb];
      assign ctl.clk_pt = pt_eval(bur_cfg_in[B].pt[QLC_BPT_CLK], lits);
      assign ctl.rst = pt_eval(bur_cfg_in[B].pt[QLC_BPT_RST], lits);
      assign ctl.pre = pt_eval(bur_cfg_in[B].pt[QLC_BPT_PRE], lits);

      qlc_ff u_ff (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .ctl_in(ctl),
        .clk_src_in(bur_cfg_in[B].clk),
        .ded_sync_in(ded_sync_q),
        .scan_en_in(scan_sync_q[1]),
        .scan_d_in(chain_in[2 * QLC_IO + B]),
        .q_out(bur_q[B])
      );
    end
  end

  property p_latch_hold;
    @(posedge clk_in) disable iff (!reset_n_in)
      (lat_gate == '0) |=> $stable(lat_q);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch moved while closed");

  property p_latch_follow;
    @(posedge clk_in) disable iff (!reset_n_in)
      1'b1 |=> (((lat_q ^ $past(io_sync_q)) & $past(lat_gate)) == '0);
  endproperty
  a_latch_follow: assert property (p_latch_follow) else $error("open latch missed pin");

  property p_reg_out;
    @(posedge clk_in) disable iff (!reset_n_in)
      $rose(reset_n_in) |-> ((io_pin_out & ~comb_mask) == '0);
  endproperty
  a_reg_out: assert property (p_reg_out) else $error("registered pin not clear");

  property p_scan_out;
    @(posedge clk_in) disable iff (!reset_n_in)
      (scan_cnt_q >= QLC_SCAN_CNT_W'(QLC_FF)) |-> (scan_data_out == $past(scan_sync_q[0], 128));
  endproperty
  a_scan_out: assert property (p_scan_out) else $error("scan readback wrong");
endmodule

// ===== rtl/qlc_ff.sv
// One fabric flip-flop with selectable clock event, reset, preset and scan path.
// Assumes the dedicated pin values arrive already synchronised to clk_in.
`timescale 1ns/1ns
module qlc_ff
  import qlc_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire qlc_ff_ctl_type ctl_in,
  input wire qlc_clk_type clk_src_in,
  input wire logic [QLC_DED-1:0] ded_sync_in,
  input wire logic scan_en_in,
  input wire logic scan_d_in,
  output logic q_out
);
  logic edge_src;
  logic src_q;
  logic rise;

  // Pin clock gives the synchronous mode, product term the asynchronous one
  assign edge_src = clk_src_in.use_pin ? ded_sync_in[clk_src_in.pin] : ctl_in.clk_pt;
  assign rise = edge_src & ~src_q;

  // Previous clock level, so a rising term is seen once per edge
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      src_q <= 1'b0;
    end else begin
      src_q <= edge_src;
    end
  end

  // Scan beats all but power-up reset; reset beats preset
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q_out <= 1'b0;
    end else if (scan_en_in) begin
      q_out <= scan_d_in;
    end else if (ctl_in.rst) begin
      q_out <= 1'b0;
    end else if (ctl_in.pre) begin
      q_out <= 1'b1;
    end else if (rise) begin
      q_out <= ctl_in.d;
    end
  end

  property p_reset_wins;
    @(posedge clk_in) disable iff (!reset_n_in)
      (!scan_en_in && ctl_in.rst && ctl_in.pre) |=> !q_out;
  endproperty
  a_reset_wins: assert property (p_reset_wins) else $error("preset beat reset");

  property p_preset;
    @(posedge clk_in) disable iff (!reset_n_in)
      (!scan_en_in && !ctl_in.rst && ctl_in.pre) |=> q_out;
  endproperty
  a_preset: assert property (p_preset) else $error("preset not applied");

  property p_capture;
    @(posedge clk_in) disable iff (!reset_n_in)
      (!scan_en_in && !ctl_in.rst && !ctl_in.pre && rise) |=> (q_out == $past(ctl_in.d));
  endproperty
  a_capture: assert property (p_capture) else $error("clock edge did not capture");

  property p_hold;
    @(posedge clk_in) disable iff (!reset_n_in)
      (!scan_en_in && !ctl_in.rst && !ctl_in.pre && !rise) |=> $stable(q_out);
  endproperty
  a_hold: assert property (p_hold) else $error("flip-flop moved without event");

  property p_scan;
    @(posedge clk_in) disable iff (!reset_n_in)
      scan_en_in |=> (q_out == $past(scan_d_in));
  endproperty
  a_scan: assert property (p_scan) else $error("scan shift lost");

  property p_powerup;
    @(posedge clk_in) disable iff (!reset_n_in)
      $rose(reset_n_in) |-> !q_out;
  endproperty
  a_powerup: assert property (p_powerup) else $error("not clear after reset");
endmodule

// ===== rtl/qlc_pkg.sv
// Shared sizes, literal layout and configuration carriers of the quadrant logic fabric.
// Assumes configuration words are static while the fabric runs.
package qlc_pkg;
  // Fabric sizes
  localparam int QLC_QUADS = 4;
  localparam int QLC_IO_PER_Q = 13;
  localparam int QLC_BUR_PER_Q = 6;
  localparam int QLC_IO = QLC_QUADS * QLC_IO_PER_Q;
  localparam int QLC_BUR = QLC_QUADS * QLC_BUR_PER_Q;
  localparam int QLC_DED = 8;
  localparam int QLC_FF = 2 * QLC_IO + QLC_BUR;
  localparam int QLC_REG_FF = 2 * QLC_IO_PER_Q + QLC_BUR_PER_Q;
  localparam int QLC_SUM_PTS = 4;
  localparam int QLC_SYNC_STAGES = 2;

  // Literal layout of one quadrant's product-term inputs
  localparam int QLC_UNI_BASE = 0;
  localparam int QLC_REG_BASE = QLC_UNI_BASE + 2 * QLC_IO;
  localparam int QLC_DED_BASE = QLC_REG_BASE + 2 * QLC_REG_FF;
  localparam int QLC_FB_BASE = QLC_DED_BASE + 2 * QLC_DED;
  localparam int QLC_LITS = QLC_FB_BASE + QLC_BUR_PER_Q;

  // Product-term slots of an I/O cell
  localparam int QLC_IO_PTS = 19;
  localparam int QLC_PT_S0 = 0;
  localparam int QLC_PT_S1 = 4;
  localparam int QLC_PT_S2 = 8;
  localparam int QLC_PT_OE = 12;
  localparam int QLC_PT_CLK1 = 13;
  localparam int QLC_PT_RST1 = 14;
  localparam int QLC_PT_PRE1 = 15;
  localparam int QLC_PT_CLK2 = 16;
  localparam int QLC_PT_RST2 = 17;
  localparam int QLC_PT_PRE2 = 18;

  // Product-term slots of a buried cell
  localparam int QLC_BUR_PTS = 7;
  localparam int QLC_BPT_S0 = 0;
  localparam int QLC_BPT_CLK = 4;
  localparam int QLC_BPT_RST = 5;
  localparam int QLC_BPT_PRE = 6;

  // Combinational output widths: 4, 8 or 12 product terms
  localparam logic [1:0] QLC_W4 = 2'h0;
  localparam logic [1:0] QLC_W8 = 2'h1;

  localparam int QLC_SCAN_CNT_W = 8;

  typedef logic [QLC_LITS-1:0] qlc_pt_type;
  typedef logic [QLC_SUM_PTS*QLC_LITS-1:0] qlc_sum_type;

  typedef struct packed {
    logic use_pin;
    logic [2:0] pin;
  } qlc_clk_type;

  typedef struct packed {
    qlc_pt_type [QLC_IO_PTS-1:0] pt;
    logic comb_out;
    logic [1:0] comb_w;
    logic share2;
    qlc_clk_type [1:0] clk;
    logic lat_use;
    logic lat_en;
  } qlc_io_cfg_type;

  typedef struct packed {
    qlc_pt_type [QLC_BUR_PTS-1:0] pt;
    qlc_clk_type clk;
  } qlc_bur_cfg_type;

  typedef struct packed {
    logic d;
    logic clk_pt;
    logic rst;
    logic pre;
  } qlc_ff_ctl_type;
endpackage

// ===== sim/qlc_board.sv
// Board-side model of the pin wires seen by the fabric.
// Assumes the bench supplies the board's own level for every pin.
`timescale 1ns/1ns
module qlc_board
  import qlc_pkg::*;
(
  input wire logic [QLC_IO-1:0] board_drive_in,
  input wire logic [QLC_IO-1:0] pin_drive_in,
  input wire logic [QLC_IO-1:0] pin_oe_in,
  output logic [QLC_IO-1:0] pin_level_out
);
  // Board drive is weak: it yields wherever the fabric enables its driver
  always_comb begin
    for (int i = 0; i < QLC_IO; i++) begin
      pin_level_out[i] = pin_oe_in[i] ? pin_drive_in[i] : board_drive_in[i];
    end
  end
endmodule

// ===== sim/qlc_fabric_test.sv
// Self-checking bench of the quadrant logic fabric.
// Assumes config changes only under reset and pins settle within four cycles.
`timescale 1ns/1ns
module qlc_fabric_test
  import qlc_pkg::*;
();
  logic clk_in, reset_n_in, scan_en, scan_d, scan_out;
  logic [QLC_IO-1:0] board_q, pin_lvl, pin_out, pin_oe;
  logic [QLC_DED-1:0] ded;
  qlc_io_cfg_type [QLC_IO-1:0] io_cfg;
  qlc_bur_cfg_type [QLC_BUR-1:0] bur_cfg;
  qlc_pt_type [QLC_QUADS-1:0] lat_pt;
  int miscompares, total_checks, cycles;
  // A term holding a pin and its complement is never true
  localparam qlc_pt_type F_PT = (qlc_pt_type'(1'h1) << QLC_IO) | qlc_pt_type'(1'h1);

  qlc_fabric qlc_fabric_inst (.clk_in(clk_in), .reset_n_in(reset_n_in), .io_pin_in(pin_lvl),
    .io_pin_out(pin_out), .io_pin_oe_out(pin_oe), .ded_pin_in(ded), .scan_en_in(scan_en),
    .scan_data_in(scan_d), .scan_data_out(scan_out), .io_cfg_in(io_cfg),
    .bur_cfg_in(bur_cfg), .lat_pt_in(lat_pt));
  qlc_board qlc_board_inst (.board_drive_in(board_q), .pin_drive_in(pin_out),
    .pin_oe_in(pin_oe), .pin_level_out(pin_lvl));

  // Clock
  initial begin
    clk_in = 1'h0;
    forever #10 clk_in = ~clk_in;
  end

  // Hang guard; the full run needs well under 1000 cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end

  function automatic qlc_pt_type lit(input int k);
    lit = qlc_pt_type'(1'h1) << k;
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Every term false: flops hold, pins undriven
  task automatic cfg_clear();
    io_cfg = '0;
    bur_cfg = '0;
    for (int i = 0; i < QLC_IO; i++) begin
      for (int j = 0; j < QLC_IO_PTS; j++) io_cfg[i].pt[j] = F_PT;
    end
    for (int i = 0; i < QLC_BUR; i++) begin
      for (int j = 0; j < QLC_BUR_PTS; j++) bur_cfg[i].pt[j] = F_PT;
    end
    for (int q = 0; q < QLC_QUADS; q++) lat_pt[q] = F_PT;
  endtask

  // Preload through the chain, then one more shift to show direction
  task automatic t_scan();
    logic [127:0] pat;
    logic [63:0] exp;
    pat = 128'hF0E1_D2C3_B4A5_9687_7869_5A4B_3C2D_1E0F;
    check(64'({scan_out, pin_out}), 64'h0);
    scan_en = 1'h1;
    for (int k = 0; k < 128; k++) begin
      scan_d = pat[k];
      step(1);
    end
    scan_en = 1'h0;
    step(4);
    exp = '0;
    for (int k = 0; k < QLC_IO; k++) exp[k] = pat[127-k];
    check(64'(pin_out), exp);
    check(64'(scan_out), 64'(pat[0]));
    scan_en = 1'h1;
    scan_d = 1'h0;
    step(1);
    scan_en = 1'h0;
    step(4);
    check(64'({scan_out, pin_out[1:0]}), 64'({pat[1], pat[127], 1'h0}));
  endtask

  // Cells used by the functional scenarios
  task automatic t_cfg();
    io_cfg[4].pt[QLC_PT_PRE1] = '0;
    io_cfg[5].pt[QLC_PT_PRE1] = '0;
    io_cfg[5].pt[QLC_PT_RST1] = '0;
    for (int c = 0; c < 52; c++) begin
      if (c < 2 || c == 6 || c == 8 || c == 9 || c == 40) io_cfg[c].comb_out = 1'h1;
    end
    io_cfg[0].comb_w = QLC_W8;
    io_cfg[0].pt[QLC_PT_S0] = lit(1);
    io_cfg[0].pt[QLC_PT_S1] = lit(QLC_DED_BASE);
    io_cfg[1].pt[QLC_PT_S0] = lit(1);
    io_cfg[1].pt[QLC_PT_S1] = lit(QLC_DED_BASE);
    io_cfg[6].pt[QLC_PT_S0] = lit(QLC_FB_BASE);
    bur_cfg[0].pt[QLC_BPT_S0] = lit(6);
    io_cfg[9].pt[QLC_PT_S0] = lit(QLC_REG_BASE + 4) | lit(QLC_REG_BASE + QLC_REG_FF + 5);
    io_cfg[9].pt[QLC_PT_OE] = '0;
    io_cfg[40].pt[QLC_PT_S0] = lit(QLC_IO);
    io_cfg[2].clk[0].use_pin = 1'h1;
    io_cfg[2].clk[0].pin = 3'h2;
    io_cfg[2].pt[QLC_PT_S1] = lit(10);
    io_cfg[3].pt[QLC_PT_CLK1] = lit(QLC_DED_BASE + 3);
    io_cfg[3].pt[QLC_PT_S1] = lit(11);
    io_cfg[7].lat_use = 1'h1;
    io_cfg[7].lat_en = 1'h1;
    lat_pt[0] = lit(QLC_DED_BASE + 1);
    io_cfg[8].pt[QLC_PT_S0] = lit(7);
    // Quadrant 1: twelve-term output, shared bottom group, flop 2 on a pin clock
    io_cfg[20].comb_out = 1'h1;
    io_cfg[20].comb_w = 2'h2;
    io_cfg[20].pt[QLC_PT_S2] = lit(21);
    io_cfg[14].share2 = 1'h1;
    io_cfg[14].pt[QLC_PT_S2] = lit(15);
    io_cfg[14].pt[QLC_PT_CLK1] = lit(QLC_DED_BASE + 4);
    io_cfg[14].clk[1].use_pin = 1'h1;
    io_cfg[14].clk[1].pin = 3'h5;
    io_cfg[14].pt[QLC_PT_RST2] = lit(QLC_DED_BASE + 6);
    // Flop 2 of cell 14 reaches a pin only through the regional bus
    io_cfg[16].comb_out = 1'h1;
    io_cfg[16].pt[QLC_PT_S0] = lit(QLC_REG_BASE + QLC_IO_PER_Q + 1);
  endtask

  // Twelve-term output, bottom sum shared into flop 1, flop 2 on pin clock and own reset
  task automatic t_wide();
    board_q[21] = 1'h1;
    board_q[15] = 1'h1;
    step(4);
    check(64'({pin_out[20], pin_out[14], pin_out[16]}), 64'h4);
    ded[5:4] = 2'h3;
    step(4);
    check(64'({pin_out[20], pin_out[14], pin_out[16]}), 64'h7);
    ded[6] = 1'h1;
    step(4);
    check(64'({pin_out[14], pin_out[16]}), 64'h2);
    ded[6] = 1'h0;
    board_q[21] = 1'h0;
    step(4);
    check(64'({pin_out[20], pin_out[14], pin_out[16]}), 64'h2);
  endtask

  // Sum widths, buried feedback, complement literal in the far quadrant
  task automatic t_comb();
    step(2);
    check(64'(pin_out[5:4]), 64'h1);
    board_q[1:0] = 2'h3;
    board_q[6] = 1'h1;
    step(4);
    check(64'({pin_out[40], pin_out[6], pin_out[1:0]}), 64'h7);
    board_q[1:0] = 2'h0;
    board_q[6] = 1'h0;
    ded[0] = 1'h1;
    step(4);
    check(64'({pin_out[40], pin_out[6], pin_out[1:0]}), 64'h9);
    check(64'({pin_oe[9], pin_oe[0], pin_out[9], pin_lvl[9]}), 64'hB);
  endtask

  // Pin clock and product-term clock capture only on a rise
  task automatic t_clocks();
    board_q[11:10] = 2'h3;
    step(4);
    check(64'(pin_out[3:2]), 64'h0);
    ded[3:2] = 2'h3;
    step(4);
    check(64'(pin_out[3:2]), 64'h3);
    board_q[11:10] = 2'h0;
    ded[3:2] = 2'h0;
    step(4);
    check(64'(pin_out[3:2]), 64'h3);
    ded[3:2] = 2'h3;
    step(4);
    check(64'(pin_out[3:2]), 64'h0);
  endtask

  // Quadrant latch holds the pin while its gate is closed
  task automatic t_latch();
    ded[1] = 1'h1;
    board_q[7] = 1'h1;
    step(5);
    check(64'(pin_out[8]), 64'h1);
    ded[1] = 1'h0;
    step(4);
    board_q[7] = 1'h0;
    step(5);
    check(64'(pin_out[8]), 64'h1);
    ded[1] = 1'h1;
    step(5);
    check(64'(pin_out[8]), 64'h0);
    reset_n_in = 1'h0;
    step(2);
    check(64'(pin_out[5:2]), 64'h0);
  endtask

  // Main sequence
  initial begin
    reset_n_in = 1'h0;
    scan_en = 1'h0;
    scan_d = 1'h0;
    board_q = '0;
    ded = '0;
    cfg_clear();
    step(12);
    reset_n_in = 1'h1;
    step(2);
    t_scan();
    reset_n_in = 1'h0;
    t_cfg();
    step(12);
    reset_n_in = 1'h1;
    t_comb();
    t_clocks();
    t_wide();
    t_latch();
    wrap_up();
  end
endmodule
